// file: design/alc_link_top.sv
// ascii link message engine: request receive, checksum, timeouts, reply framing
// assumes a uart on the same clock delivers rx characters and accepts tx characters,
// and that the controller core pulses scan_end at each end-of-scan point
//
// How it works
// - wait setting spans 0..150 ms, 10 ms steps
// - wait step is one hex character 0..F
// - reply waits for wait time, then scan end (run) or ms tick (stopped)
// - checksum is low byte of character sum
// - checksum enabled: append on send, check receive
// - checksum disabled: no append, no check
// - receive gap past timeout flags error, resets
// - per-channel timeout registers count 10 ms units
// - timeout range 1..255 parameter (channel 1 only), 1..3276 program and channel 2
// - timeout value zero means 100 ms
// - new timeout applies from next received character
// - requests serviced at end of scan in run mode, on ms tick when stopped
// - running within one scan, stopped about 1 ms
// - characters framed 7/8 data, parity, stop bits
// - single bit access: 31H on, 30H off
// - sixteen bits as four hex digits, msb first
// - word data as four hex digits, msb first
// - data in reply area or request area
// - format or checksum error answered with NAK 15H; timeout gets no reply
// - clear or end code resets, no reply
`timescale 1ns/1ps
module alc_link_top #(
  parameter int CYC_PER_MS = alc_pkg::CYC_PER_MS,
  parameter int DEPTH      = 32
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  input  wire logic        run_mode,
  input  wire logic        scan_end,
  output logic             link_busy
);
  import alc_pkg::*;

  initial begin
    if (DEPTH < 8 || DEPTH > 128)
      $error("alc_link_top: DEPTH must be 8..128");
  end

  localparam logic [7:0] DEPTH_B = 8'(DEPTH);

  typedef struct packed {
    alc_state_e             st;
    logic                   sum_en;
    logic                   chan_sel;
    logic                   seven;
    logic                   param_mode;
    logic                   go;
    logic                   nak;
    logic                   bad;
    logic                   req_ready;
    logic                   to_err;
    logic                   sum_err;
    logic                   busy;
    logic                   wreq;
    logic [11:0]            to_ch1;
    logic [11:0]            to_ch2;
    logic [11:0]            eff_to;
    logic [11:0]            to_cnt;
    logic [7:0]             frame_len;
    logic [7:0]             idx;
    logic [7:0]             rd_ptr;
    logic [7:0]             sum_hi;
    logic [7:0]             tx_len;
    logic [7:0]             tx_idx;
    logic [7:0]             wait_cnt;
    logic [7:0]             tx_data;
    logic [3:0]             wait_steps;
    logic                   tx_valid;
    logic [31:0]            rdata;
    logic [DEPTH-1:0][7:0]  rx_buf;
    logic [DEPTH-1:0][7:0]  tx_buf;
  } alc_top_s;

  alc_top_s s;
  alc_top_s next_s;

  logic       tick_ms;
  logic       tick_step;
  logic [7:0] rx_sum;
  logic [7:0] tx_sum;
  logic [7:0] rx_char;
  logic       rx_ctl;
  logic       rx_clr;
  logic       rx_add;
  logic       tx_acc;
  logic       tx_clr;
  logic       tx_add;
  logic       wait_ok;
  logic       service;
  logic [11:0] sel_to;

  alc_tick_div #(
    .CYC_PER_MS (CYC_PER_MS),
    .STEP_MS    (STEP_MS)
  ) u_div (
    .clk       (clk),
    .reset     (reset),
    .tick_ms   (tick_ms),
    .tick_step (tick_step)
  );

  alc_sum_acc u_rx_sum (
    .clk   (clk),
    .reset (reset),
    .clr   (rx_clr),
    .add   (rx_add),
    .din   (rx_char),
    .sum   (rx_sum)
  );

  alc_sum_acc u_tx_sum (
    .clk   (clk),
    .reset (reset),
    .clr   (tx_clr),
    .add   (tx_add),
    .din   (s.tx_data),
    .sum   (tx_sum)
  );

  // seven-bit framing leaves the top data bit undefined, so it is masked
  assign rx_char = s.seven ? {1'b0, rx_data[6:0]} : rx_data;
  assign rx_ctl  = (rx_char == CODE_ENQ) || (rx_char == CODE_EOT) || (rx_char == CODE_CLR);
  assign rx_clr  = rx_valid && (rx_char == CODE_ENQ);
  assign rx_add  = rx_valid && !rx_ctl && (s.st == ST_RX);
  assign tx_acc  = s.tx_valid && tx_ready;
  assign tx_clr  = (s.st == ST_HOLD) && (next_s.st == ST_STX);
  assign tx_add  = tx_acc && ((s.st == ST_BODY) || (s.st == ST_ETX));
  // the millisecond phase is free running, so one extra tick guarantees the minimum
  assign wait_ok = s.wait_cnt > ({4'h0, s.wait_steps} * 8'(STEP_MS));
  assign service = run_mode ? scan_end : tick_ms;
  assign sel_to  = s.chan_sel ? s.to_ch2 : s.to_ch1;

  always_comb begin
    logic [8:0] tlen;
    logic [7:0] pos;
    logic [4:0] bcnt;
    logic [4:0] hv;
    tlen = 9'h000;
    pos  = 8'h00;
    bcnt = 5'h00;
    hv   = 5'h00;
    next_s = s;

    // bus slave: one wait cycle, data captured on the request edge
    next_s.wreq = 1'b1;
    if ((avs_read || avs_write) && s.wreq) begin
      next_s.wreq = 1'b0;
      case (avs_address)
        OFF_CTRL:      next_s.rdata = {26'h000_0000, s.param_mode, 2'b00, s.seven,
                                       s.chan_sel, s.sum_en};
        OFF_STATUS:    next_s.rdata = {8'h00, s.idx, 4'h0, s.wait_steps, 4'h0, s.busy,
                                       s.sum_err, s.to_err, s.req_ready};
        OFF_TO_CH1:    next_s.rdata = {20'h0_0000, s.to_ch1};
        OFF_TO_CH2:    next_s.rdata = {20'h0_0000, s.to_ch2};
        OFF_RX_DATA:   next_s.rdata = (s.rd_ptr < DEPTH_B) ?
                                      {24'h00_0000, s.rx_buf[s.rd_ptr]} : 32'h0000_0000;
        OFF_RX_PTR:    next_s.rdata = {24'h00_0000, s.rd_ptr};
        OFF_TX_LEN:    next_s.rdata = {24'h00_0000, s.tx_len};
        OFF_FRAME_LEN: next_s.rdata = {24'h00_0000, s.frame_len};
        default:       next_s.rdata = 32'h0000_0000;
      endcase
    end

    if (avs_read && !s.wreq && avs_address == OFF_RX_DATA) next_s.rd_ptr = s.rd_ptr + 8'h01;

    if (avs_write && !s.wreq) begin
      case (avs_address)
        OFF_CTRL: begin
          next_s.sum_en     = avs_writedata[CB_SUM_EN];
          next_s.chan_sel   = avs_writedata[CB_CHAN];
          next_s.seven      = avs_writedata[CB_SEVEN];
          next_s.param_mode = avs_writedata[CB_PARAM];
          if (avs_writedata[CB_GO]) next_s.go = 1'b1;
          if (avs_writedata[CB_NAK]) next_s.nak = 1'b1;
        end
        OFF_STATUS: begin
          if (avs_writedata[SB_TO_ERR]) next_s.to_err = 1'b0;
          if (avs_writedata[SB_SUM_ERR]) next_s.sum_err = 1'b0;
        end
        OFF_TO_CH1: next_s.to_ch1 = to_clamp(avs_writedata[11:0],
                                     s.param_mode ? TO_PAR_MAX : TO_PRG_MAX);
        OFF_TO_CH2: next_s.to_ch2 = to_clamp(avs_writedata[11:0], TO_PRG_MAX);
        OFF_RX_PTR: next_s.rd_ptr = avs_writedata[7:0];
        OFF_FRAME_LEN: next_s.frame_len = avs_writedata[7:0];
        OFF_TX_LEN: next_s.tx_len = (avs_writedata[7:0] > DEPTH_B) ? DEPTH_B :
                                    avs_writedata[7:0];
        OFF_TX_CHAR: begin
          if (s.tx_len < DEPTH_B) begin
            next_s.tx_buf[s.tx_len] = avs_writedata[7:0];
            next_s.tx_len = s.tx_len + 8'h01;
          end
        end
        OFF_TX_WORD: begin
          for (int i = 0; i < 4; i++) begin
            pos = s.tx_len + 8'(i);
            if (pos < DEPTH_B)
              next_s.tx_buf[pos] = hex_char(4'(avs_writedata[15:0] >> (12 - 4 * i)));
          end
          tlen = {1'b0, s.tx_len} + 9'h004;
          next_s.tx_len = (tlen > {1'b0, DEPTH_B}) ? DEPTH_B : tlen[7:0];
        end
        OFF_TX_BITS: begin
          bcnt = avs_writedata[BITS_CNT_LSB +: 5];
          if (bcnt > 5'h10) bcnt = 5'h10;
          for (int i = 0; i < 16; i++) begin
            pos = s.tx_len + 8'(i);
            if (5'(i) < bcnt && pos < DEPTH_B)
              next_s.tx_buf[pos] = avs_writedata[i] ? CHAR_ON : CHAR_OFF;
          end
          tlen = {1'b0, s.tx_len} + {4'h0, bcnt};
          next_s.tx_len = (tlen > {1'b0, DEPTH_B}) ? DEPTH_B : tlen[7:0];
        end
        default: begin
        end
      endcase
    end

    // receive side
    if (rx_valid) begin
      if (rx_char == CODE_EOT || rx_char == CODE_CLR) begin
        next_s.st = ST_IDLE;
        next_s.req_ready = 1'b0;
        next_s.go = 1'b0;
        next_s.nak = 1'b0;
        next_s.tx_valid = 1'b0;
      end else if (rx_char == CODE_ENQ) begin
        next_s.st = ST_RX;
        next_s.idx = 8'h00;
        next_s.bad = 1'b0;
        next_s.req_ready = 1'b0;
        next_s.nak = 1'b0;
        next_s.go = 1'b0;
        next_s.tx_valid = 1'b0;
        next_s.to_cnt = 12'h000;
        next_s.eff_to = (sel_to == 12'h000) ? TO_ZERO_STEPS : sel_to;
      end else if (s.st == ST_RX || s.st == ST_SUMH || s.st == ST_SUML) begin
        next_s.to_cnt = 12'h000;
        next_s.eff_to = (sel_to == 12'h000) ? TO_ZERO_STEPS : sel_to;
        case (s.st)
          ST_RX: begin
            if (s.idx < DEPTH_B) next_s.rx_buf[s.idx] = rx_char;
            else next_s.bad = 1'b1;
            if (s.idx == WAIT_POS) begin
              hv = hex_val(rx_char);
              next_s.wait_steps = hv[3:0];
              if (!hv[4] || hv[3:0] > WAIT_MAX_STEPS) next_s.bad = 1'b1;
            end
            next_s.idx = s.idx + 8'h01;
            if (s.idx + 8'h01 >= s.frame_len) begin
              if (s.sum_en) begin
                next_s.st = ST_SUMH;
              end else begin
                next_s.st = ST_HOLD;
                next_s.wait_cnt = 8'h00;
                next_s.nak = next_s.bad;
                next_s.req_ready = !next_s.bad;
              end
            end
          end
          ST_SUMH: begin
            next_s.sum_hi = rx_char;
            next_s.st = ST_SUML;
          end
          ST_SUML: begin
            next_s.st = ST_HOLD;
            next_s.wait_cnt = 8'h00;
            if (s.sum_hi != hex_char(rx_sum[7:4]) || rx_char != hex_char(rx_sum[3:0])) begin
              next_s.sum_err = 1'b1;
              next_s.nak = 1'b1;
            end else begin
              next_s.nak = s.bad;
              next_s.req_ready = !s.bad;
            end
          end
          default: begin
          end
        endcase
      end
    end else if ((s.st == ST_RX || s.st == ST_SUMH || s.st == ST_SUML) && tick_step) begin
      next_s.to_cnt = s.to_cnt + 12'h001;
      if (s.to_cnt + 12'h001 >= s.eff_to) begin
        next_s.to_err = 1'b1;
        next_s.st = ST_IDLE;
      end
    end

    // reply side
    if (s.st == ST_HOLD && !rx_valid) begin
      if (tick_ms && s.wait_cnt != 8'hFF) next_s.wait_cnt = s.wait_cnt + 8'h01;
      if (wait_ok && service && (s.nak || s.go)) begin
        next_s.st = s.nak ? ST_NAK : ST_STX;
        next_s.go = 1'b0;
        next_s.req_ready = 1'b0;
      end
    end

    if (s.st inside {ST_STX, ST_BODY, ST_ETX, ST_CSH, ST_CSL, ST_NAK} && !rx_valid) begin
      if (!s.tx_valid) begin
        next_s.tx_valid = 1'b1;
        case (s.st)
          ST_STX:  next_s.tx_data = CODE_STX;
          ST_BODY: next_s.tx_data = s.tx_buf[s.tx_idx];
          ST_ETX:  next_s.tx_data = CODE_ETX;
          ST_CSH:  next_s.tx_data = hex_char(tx_sum[7:4]);
          ST_CSL:  next_s.tx_data = hex_char(tx_sum[3:0]);
          default: next_s.tx_data = CODE_NAK;
        endcase
      end else if (tx_acc) begin
        next_s.tx_valid = 1'b0;
        case (s.st)
          ST_STX: begin
            next_s.tx_idx = 8'h00;
            next_s.st = (s.tx_len == 8'h00) ? ST_ETX : ST_BODY;
          end
          ST_BODY: begin
            next_s.tx_idx = s.tx_idx + 8'h01;
            if (s.tx_idx + 8'h01 >= s.tx_len) next_s.st = ST_ETX;
          end
          ST_ETX:  next_s.st = s.sum_en ? ST_CSH : ST_IDLE;
          ST_CSH:  next_s.st = ST_CSL;
          ST_CSL:  next_s.st = ST_IDLE;
          default: begin
            next_s.st = ST_IDLE;
            next_s.nak = 1'b0;
          end
        endcase
      end
    end

    next_s.busy = (next_s.st != ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.wreq <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = s.wreq;
  assign tx_valid        = s.tx_valid;
  assign tx_data         = s.tx_data;
  assign link_busy       = s.busy;
endmodule

// file: design/alc_pkg.sv
// constants, encodings and helper functions for the ascii link message block
// assumes a single 20 MHz clock and a byte-wide character port from a uart
package alc_pkg;

  localparam int CLK_HZ    = 20_000_000;
  localparam int MS_PER_S  = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

  localparam int STEP_MS        = 10;
  localparam int WAIT_MAX_MS    = 150;
  localparam int TO_ZERO_MS     = 100;
  localparam logic [3:0]  WAIT_MAX_STEPS = 4'(WAIT_MAX_MS / STEP_MS);
  localparam logic [11:0] TO_ZERO_STEPS  = 12'(TO_ZERO_MS / STEP_MS);
  localparam logic [11:0] TO_PRG_MAX     = 12'h0_CCC;
  localparam logic [11:0] TO_PAR_MAX     = 12'h0_0FF;

  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_TO_CH1    = 8'h08;
  localparam logic [7:0] OFF_TO_CH2    = 8'h0C;
  localparam logic [7:0] OFF_RX_DATA   = 8'h10;
  localparam logic [7:0] OFF_RX_PTR    = 8'h14;
  localparam logic [7:0] OFF_TX_CHAR   = 8'h18;
  localparam logic [7:0] OFF_TX_WORD   = 8'h1C;
  localparam logic [7:0] OFF_TX_BITS   = 8'h20;
  localparam logic [7:0] OFF_TX_LEN    = 8'h24;
  localparam logic [7:0] OFF_FRAME_LEN = 8'h28;

  localparam int CB_SUM_EN = 0;
  localparam int CB_CHAN   = 1;
  localparam int CB_SEVEN  = 2;
  localparam int CB_GO     = 3;
  localparam int CB_NAK    = 4;
  localparam int CB_PARAM  = 5;

  localparam int SB_REQ      = 0;
  localparam int SB_TO_ERR   = 1;
  localparam int SB_SUM_ERR  = 2;
  localparam int SB_BUSY     = 3;
  localparam int SB_WAIT_LSB = 8;
  localparam int SB_LEN_LSB  = 16;
  localparam int BITS_CNT_LSB = 16;

  localparam logic [7:0] CODE_STX = 8'h02;
  localparam logic [7:0] CODE_ETX = 8'h03;
  localparam logic [7:0] CODE_EOT = 8'h04;
  localparam logic [7:0] CODE_ENQ = 8'h05;
  localparam logic [7:0] CODE_CLR = 8'h0C;
  localparam logic [7:0] CODE_NAK = 8'h15;
  localparam logic [7:0] CHAR_ON  = 8'h31;
  localparam logic [7:0] CHAR_OFF = 8'h30;
  localparam logic [7:0] WAIT_POS = 8'h06;

  typedef enum logic [10:0] {
    ST_IDLE = 11'b000_0000_0001,
    ST_RX   = 11'b000_0000_0010,
    ST_SUMH = 11'b000_0000_0100,
    ST_SUML = 11'b000_0000_1000,
    ST_HOLD = 11'b000_0001_0000,
    ST_STX  = 11'b000_0010_0000,
    ST_BODY = 11'b000_0100_0000,
    ST_ETX  = 11'b000_1000_0000,
    ST_CSH  = 11'b001_0000_0000,
    ST_CSL  = 11'b010_0000_0000,
    ST_NAK  = 11'b100_0000_0000
  } alc_state_e;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // returns {valid, nibble}; only upper case digits are legal
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
    if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
    return 5'h00;
  endfunction

  function automatic logic [11:0] to_clamp(input logic [11:0] v, input logic [11:0] lim);
    return (v > lim) ? lim : v;
  endfunction

endpackage

// file: design/alc_sum_acc.sv
// eight-bit additive checksum accumulator
// assumes clr and add come from logic on the same clock; clr has priority
`timescale 1ns/1ps
module alc_sum_acc (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clr,
  input  wire logic       add,
  input  wire logic [7:0] din,
  output logic      [7:0] sum
);
  import alc_pkg::*;

  typedef struct packed {
    logic [7:0] acc;
  } alc_sum_s;

  alc_sum_s s;
  alc_sum_s next_s;

  always_comb begin
    next_s = s;
    if (clr) next_s.acc = 8'h00;
    else if (add) next_s.acc = s.acc + din;
  end

  always_ff @(posedge clk) begin
    if (reset) s <= '0;
    else s <= next_s;
  end

  assign sum = s.acc;
endmodule

// file: design/alc_tick_div.sv
// millisecond and 10 ms enable pulses derived from the system clock
// assumes clk is the block clock; pulses are one cycle wide
`timescale 1ns/1ps
module alc_tick_div #(
  parameter int CYC_PER_MS = alc_pkg::CYC_PER_MS,
  parameter int STEP_MS    = alc_pkg::STEP_MS
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick_ms,
  output logic      tick_step
);
  import alc_pkg::*;

  initial begin
    if (CYC_PER_MS < 2 || CYC_PER_MS > 65536 || STEP_MS < 1 || STEP_MS > 255)
      $error("alc_tick_div: unsupported divider settings");
  end

  typedef struct packed {
    logic [15:0] cyc;
    logic [7:0]  ms;
    logic        t_ms;
    logic        t_step;
  } alc_div_s;

  alc_div_s s;
  alc_div_s next_s;

  always_comb begin
    next_s = s;
    next_s.t_ms = 1'b0;
    next_s.t_step = 1'b0;
    if (s.cyc == 16'(CYC_PER_MS - 1)) begin
      next_s.cyc = 16'h0000;
      next_s.t_ms = 1'b1;
      if (s.ms == 8'(STEP_MS - 1)) begin
        next_s.ms = 8'h00;
        next_s.t_step = 1'b1;
      end else begin
        next_s.ms = s.ms + 8'h01;
      end
    end else begin
      next_s.cyc = s.cyc + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) s <= '0;
    else s <= next_s;
  end

  assign tick_ms = s.t_ms;
  assign tick_step = s.t_step;
endmodule

// file: dv/alc_host_model.sv
// host computer model: sends request characters and accepts reply characters
// assumes the block clock; a character arrives as a one-cycle strobe
`timescale 1ns/1ps
module alc_host_model (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            tx_ready
);
  int seed = 94;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  // random stalls so prompt and slow acceptance both occur
  always @(posedge clk) tx_ready <= ($random(seed) % 3) != 0;
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  // whole eight-bit characters; the uart adds start, parity and stop bits
  task automatic send_char(input logic [7:0] c);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~c;
    repeat (8) @(posedge clk);  // character gap kept well inside the timeout
  endtask
  // skew corrupts the checksum on purpose
  task automatic send_req(input logic [55:0] body, input logic sum_on, input logic [7:0] skew);
    logic [7:0] s;
    s = 8'h00;
    send_char(8'h05);
    for (int i = 6; i >= 0; i--) begin
      send_char(body[i*8 +: 8]);
      s = s + body[i*8 +: 8];
    end
    s = s + skew;
    if (sum_on) begin
      send_char(hx(s[7:4]));
      send_char(hx(s[3:0]));
    end
  endtask
endmodule

// file: dv/alc_link_top_asserts.sv
// checker for the ascii link block: bus handshake, reply pacing, clear codes
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module alc_link_top_asserts #(
  parameter int CYC_PER_MS = alc_pkg::CYC_PER_MS,
  parameter int DEPTH      = 32
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic        run_mode,
  input wire logic        scan_end,
  input wire logic        link_busy
);
  import alc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic clr_code;
  assign clr_code = rx_valid && (rx_data == CODE_EOT || rx_data == CODE_CLR);
  a_reset_idle: assert property (disable iff (1'b0) reset |=> avs_waitrequest && !tx_valid &&
      !link_busy && avs_readdata == 32'h0000_0000) else $error("outputs not idle after reset");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest) else $error("bus request not answered after one wait cycle");
  a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> (tx_valid && $stable(tx_data)) ||
      $past(clr_code)) else $error("reply character changed before acceptance");
  a_nak_alone: assert property (tx_valid && tx_ready && tx_data == CODE_NAK |=>
      !tx_valid [*2] ##1 (!tx_valid && !link_busy)) else $error("nak reply not single");
  a_quiet_idle: assert property (!link_busy |-> !tx_valid)
      else $error("character sent while idle");
  // a reply in run mode may only open just after an end-of-scan pulse
  a_scan_start: assert property ($rose(tx_valid) && tx_data == CODE_STX && run_mode |->
      $past(scan_end) || $past(scan_end, 2) || $past(scan_end, 3) || $past(scan_end, 4))
      else $error("reply opened away from scan end");
  a_clear_quiet: assert property (clr_code |-> ##2 (!tx_valid && !link_busy) [*3])
      else $error("clear code did not end the sequence");
  c_nak_sent: cover property (tx_valid && tx_ready && tx_data == CODE_NAK);
  c_run_reply: cover property ($rose(tx_valid) && tx_data == CODE_STX && run_mode);
  c_clear: cover property (clr_code && link_busy);
endmodule

bind alc_link_top alc_link_top_asserts #(.CYC_PER_MS(CYC_PER_MS), .DEPTH(DEPTH)) u_chk (
  .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .run_mode(run_mode),
  .scan_end(scan_end), .link_busy(link_busy)
);

// file: dv/alc_link_top_tb.sv
// self-checking bench for the ascii link block with a host model on the link
// assumes 1 ms is shortened to 20 cycles through the top parameter
`timescale 1ns/1ps
module alc_link_top_tb;
  import alc_pkg::*;
  localparam int         CPM = 20;
  localparam logic [4:0] BV  = 5'b1_0110;
  logic        clk, reset, avs_read, avs_write, run_mode, scan_end;
  logic [7:0]  avs_address, rx_data, tx_data, cs;
  logic [31:0] avs_writedata, avs_readdata, last;
  logic        avs_waitrequest, rx_valid, tx_valid, tx_ready, link_busy;
  logic [63:0] rq[$];
  logic [63:0] note;
  logic [7:0]  tq[$];
  int          n_mismatch = 0, num_checks = 0, cyc = 0, seed = 94;
  alc_link_top #(.CYC_PER_MS(CPM)) dut (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .run_mode(run_mode),
    .scan_end(scan_end), .link_busy(link_busy)
  );
  alc_host_model host (
    .clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // scan end every 37 cycles stands in for the controller core
  always @(posedge clk) begin
    cyc <= cyc + 1;
    scan_end <= (cyc % 37) == 0;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // a tx character with no note waiting is compared against unknown and fails
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      note = rq.pop_front();
      check(avs_readdata & note[63:32], note[31:0] & note[63:32]);
    end
    if (tx_valid && tx_ready)
      check({24'h0, tx_data}, tq.size() ? {24'h0, tq.pop_front()} : 32'hxxxx_xxxx);
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    last = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic ptx(input logic [7:0] c);
    tq.push_back(c);
    cs = cs + c;
  endtask
  task automatic serve(input logic s, input logic [3:0] n);
    logic [15:0] wd;
    int          t0, wt;
    wd = 16'($random(seed));
    host.send_req({"00FFBR", host.hx(n)}, s, 8'h00);
    do rd(OFF_STATUS, 32'h0, 32'h0); while (last[SB_REQ] !== 1'b1);
    t0 = cyc;
    wt = n * 10 * CPM;
    rd(OFF_STATUS, {8'h00, 8'h07, 4'h0, n, 8'h01}, 32'h00FF_0F01);
    bus(1'b1, OFF_RX_PTR, 32'h0000_0000);
    rd(OFF_RX_DATA, 32'h0000_0030, 32'h0000_00FF);
    bus(1'b1, OFF_TX_LEN, 32'h0000_0000);
    bus(1'b1, OFF_TX_WORD, {16'h0000, wd});
    bus(1'b1, OFF_TX_BITS, {11'h000, 5'h05, 11'h000, BV});
    tq.push_back(CODE_STX);
    cs = 8'h00;
    for (int i = 3; i >= 0; i--) ptx(host.hx(wd[i*4 +: 4]));
    for (int i = 0; i < 5; i++) ptx({7'h18, BV[i]});
    ptx(CODE_ETX);
    if (s) begin
      tq.push_back(host.hx(cs[7:4]));
      tq.push_back(host.hx(cs[3:0]));
    end
    bus(1'b1, OFF_CTRL, {28'h0000_000, 1'b1, 2'b00, s});
    while (tx_valid !== 1'b1) @(negedge clk);
    check(32'((cyc - t0) inside {[wt - 8 : wt + 100]}), 32'h1);
    while (link_busy !== 1'b0) @(negedge clk);
    repeat (4) @(negedge clk);
    check(32'(tq.size()), 32'h0);
    repeat (60) @(posedge clk);  // host_closing_delay before the next request
  endtask
  initial begin
    reset         = 1'b1;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 8'h00;
    avs_writedata = 32'h0000_0000;
    run_mode      = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(OFF_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(OFF_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1'b1, OFF_TO_CH2, 32'h0000_0FFF);
    rd(OFF_TO_CH2, 32'h0000_0CCC, 32'hFFFF_FFFF);
    bus(1'b1, OFF_CTRL, 32'h0000_0020);
    bus(1'b1, OFF_TO_CH1, 32'h0000_0100);
    rd(OFF_TO_CH1, 32'h0000_00FF, 32'hFFFF_FFFF);
    bus(1'b1, OFF_FRAME_LEN, 32'h0000_0007);
    serve(1'b0, 4'h3);
    run_mode <= 1'b1;
    serve(1'b1, 4'h0);
    tq.push_back(CODE_NAK);
    host.send_req("00FFBR0", 1'b1, 8'h01);
    while (tq.size() != 0) @(negedge clk);
    rd(OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
    bus(1'b1, OFF_STATUS, 32'h0000_0004);
    rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0004);
    bus(1'b1, OFF_CTRL, 32'h0000_0000);
    bus(1'b1, OFF_TO_CH1, 32'h0000_0001);
    host.send_char(CODE_ENQ);
    host.send_char(8'h30);
    // the old value of one step must still govern this gap
    bus(1'b1, OFF_TO_CH1, 32'h0000_0005);
    repeat (300) @(posedge clk);
    rd(OFF_STATUS, 32'h0000_0002, 32'h0000_000A);
    bus(1'b1, OFF_STATUS, 32'h0000_0002);
    bus(1'b1, OFF_TO_CH1, 32'h0000_0000);
    host.send_char(CODE_ENQ);
    host.send_char(8'h30);
    repeat (1500) @(posedge clk);
    rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0002);
    repeat (700) @(posedge clk);
    rd(OFF_STATUS, 32'h0000_0002, 32'h0000_000A);
    bus(1'b1, OFF_CTRL, 32'h0000_0004);
    for (int i = 0; i < 2; i++) begin
      host.send_char(CODE_ENQ);
      host.send_char(8'h30);
      host.send_char(i ? 8'h8C : CODE_EOT);
      rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0009);
    end
    test_done();
  end
endmodule
